// ### design/scio_regs.svh
`ifndef SCIO_REGS_SVH
`define SCIO_REGS_SVH
// Data bus width for every DMA and I/O data word
`define SCIO_DATA_W        16
// Synchroniser depth for host strobes and acknowledges
`define SCIO_SYNC_STAGES   2
// Reset value of the DMA request level
`define SCIO_DMARQ_RST     1'b0
`endif

// ### design/scio_pkg.sv
package scio_pkg;
    // Transfer phase of the data mover
    typedef enum logic [2:0] {
        SCIO_IDLE    = 3'b000,
        SCIO_REQ     = 3'b001,
        SCIO_MW_XFER = 3'b010,
        SCIO_UD_IN   = 3'b011,
        SCIO_UD_OUT  = 3'b100
    } scio_state_t;
endpackage : scio_pkg

// ### design/scio_sync.sv
`timescale 1ns/1ps
`include "scio_regs.svh"
// Two-flop synchroniser, one generate lane per bit
module scio_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic meta_q; // First stage, read only by second stage
            logic stab_q;
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q <= 1'b1;
                    stab_q <= 1'b1;
                end else begin
                    meta_q <= async_in[i];
                    stab_q <= meta_q;
                end
            end
            assign sync_out[i] = stab_q;
        end
    endgenerate
endmodule : scio_sync

// ### design/scio_edge.sv
`timescale 1ns/1ps
// Edge finder on an already synchronised level
module scio_edge (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic level_in,
    output logic      rise,
    output logic      fall,
    output logic      any_edge
);
    logic prev_q; // Level seen one cycle ago
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level_in;
        end
    end
    assign rise     = level_in & ~prev_q;
    assign fall     = ~level_in & prev_q;
    assign any_edge = level_in ^ prev_q;
endmodule : scio_edge

// ### design/scio_port.sv
`timescale 1ns/1ps
`include "scio_regs.svh"
// Contract
// - Acknowledge I/O reads while selected
// - Request DMA when ready to move data
// - Read strobe reads, write strobe writes
// - Hold request until acknowledge, then re-request
// - True IDE: request undriven when unselected
// - DMA: enables negated, 16-bit words
// - Drive read data only during strobe
// - True IDE reads same as I/O mode; input acknowledge here is I/O mode only
// - Host not ready pauses data-in
// - Capture word on both strobe edges
// - Cable select low means master
// - Stop ends the Ultra DMA burst
module scio_port #(
    parameter int DW = `SCIO_DATA_W
) (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    // Card-side configuration and core handshakes
    input  wire logic          mode_io,
    input  wire logic          mode_true_ide,
    input  wire logic          udma_active,
    input  wire logic          udma_dir_in,
    input  wire logic          dev_selected,
    input  wire logic          drive_head_dev,
    input  wire logic          core_xfer_pending,
    input  wire logic [DW-1:0] core_rd_data,
    input  wire logic          core_rd_valid,
    output logic               core_rd_take,
    output logic [DW-1:0]      core_wr_data,
    output logic               core_wr_valid,
    output logic               dev_is_master,
    output logic               udma_burst_stop,
    // Host pins
    input  wire logic          card_enable_low_n,
    input  wire logic          card_enable_high_n,
    input  wire logic          host_io_read_strobe_n,
    input  wire logic          host_io_write_strobe_n,
    input  wire logic          dma_ack_n,
    input  wire logic          host_dma_ready_n,
    input  wire logic          host_strobe,
    input  wire logic          udma_stop,
    input  wire logic          cable_select_n,
    input  wire logic [DW-1:0] data_in,
    output logic [DW-1:0]      data_out,
    output logic               data_oe,
    output logic               input_ack_n,
    output logic               dma_req_out,
    output logic               dma_req_oe
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [8:0] s; // Synchronised host controls
    scio_sync #(.W(9)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in ({card_enable_low_n, card_enable_high_n, host_io_read_strobe_n,
                    host_io_write_strobe_n, dma_ack_n, host_dma_ready_n,
                    host_strobe, udma_stop, cable_select_n}),
        .sync_out (s)
    );
    logic ce_lo_n, ce_hi_n, rd_n, wr_n, ack_n, rdy_n, hstb, stop, cable_select_n_n;
    assign {ce_lo_n, ce_hi_n, rd_n, wr_n, ack_n, rdy_n, hstb, stop, cable_select_n_n} = s;

    // Data bus: two flops too, so a captured word settles with its strobe
    logic [DW-1:0] din_m_q;  // First stage, read only by second
    logic [DW-1:0] din_s_q;  // Settled bus word
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            din_m_q <= '0;
            din_s_q <= '0;
        end else begin
            din_m_q <= data_in;
            din_s_q <= din_m_q;
        end
    end

    // ----------------------------------------
    // Edge finders
    // ----------------------------------------
    logic hstb_any;          // Host strobe toggled
    logic wr_rise;           // Trailing edge of write strobe
    logic rd_rise;           // End of read strobe
    scio_edge u_hstb (
        .core_clk (core_clk), .rst_b (rst_b), .level_in (hstb),
        .rise (), .fall (), .any_edge (hstb_any)
    );
    scio_edge u_wr (
        .core_clk (core_clk), .rst_b (rst_b), .level_in (wr_n),
        .rise (wr_rise), .fall (), .any_edge ()
    );
    scio_edge u_rd (
        .core_clk (core_clk), .rst_b (rst_b), .level_in (rd_n),
        .rise (rd_rise), .fall (), .any_edge ()
    );

    // ----------------------------------------
    // Decoded conditions
    // ----------------------------------------
    logic card_sel;          // Either card enable low
    logic dma_ack;           // Host acknowledge asserted
    logic pio_read;          // I/O read cycle in progress
    assign card_sel = ~ce_lo_n | ~ce_hi_n;
    assign dma_ack  = ~ack_n;
    // True IDE outside Ultra DMA behaves like I/O mode
    assign pio_read = (mode_io | mode_true_ide) & ~udma_active & card_sel
                      & dev_selected & ~rd_n;

    // ----------------------------------------
    // Transfer state machine
    // ----------------------------------------
    scio_pkg::scio_state_t state_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= scio_pkg::SCIO_IDLE;
        end else begin
            unique case (state_q)
                scio_pkg::SCIO_IDLE: begin
                    // Request only when data can move
                    if (core_xfer_pending) begin
                        state_q <= scio_pkg::SCIO_REQ;
                    end
                end
                scio_pkg::SCIO_REQ: begin
                    // Request stays up until the host acknowledges
                    if (dma_ack) begin
                        if (!udma_active) begin
                            state_q <= scio_pkg::SCIO_MW_XFER;
                        end else if (udma_dir_in) begin
                            state_q <= scio_pkg::SCIO_UD_IN;
                        end else begin
                            state_q <= scio_pkg::SCIO_UD_OUT;
                        end
                    end
                end
                scio_pkg::SCIO_MW_XFER, scio_pkg::SCIO_UD_IN,
                scio_pkg::SCIO_UD_OUT: begin
                    // Stop or released acknowledge closes the burst
                    if (!dma_ack || (udma_active && stop)) begin
                        state_q <= scio_pkg::SCIO_IDLE;
                    end
                end
                default: begin
                    state_q <= scio_pkg::SCIO_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // DMA request pin
    // ----------------------------------------
    logic req_lvl;           // Request level
    logic req_en;            // Request driven
    assign req_lvl = (state_q == scio_pkg::SCIO_REQ);
    // In True IDE, float the line when the drive-head register selects the other unit
    assign req_en  = ~mode_true_ide | drive_head_dev;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_req_out <= `SCIO_DMARQ_RST;
            dma_req_oe  <= 1'b0;
        end else begin
            dma_req_out <= req_lvl & req_en;
            dma_req_oe  <= req_en;
        end
    end

    // ----------------------------------------
    // Input acknowledge
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            input_ack_n <= 1'b1;
        end else begin
            // Only I/O mode answers; memory mode leaves it idle
            input_ack_n <= ~(pio_read & mode_io);
        end
    end

    // ----------------------------------------
    // Read data drive
    // ----------------------------------------
    logic mw_rd;             // Multiword read strobe active
    logic ud_send;           // Ultra DMA data-in may advance
    // Read strobe means device-to-host during Multiword DMA
    assign mw_rd   = (state_q == scio_pkg::SCIO_MW_XFER) & ~rd_n;
    // Host not ready pauses the data-in burst
    assign ud_send = (state_q == scio_pkg::SCIO_UD_IN) & ~rdy_n;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= '0;
            data_oe  <= 1'b0;
        end else begin
            // Bus is released one cycle after the synchronised strobe is seen high
            data_oe <= pio_read | mw_rd | ud_send;
            if (core_rd_valid && (pio_read || mw_rd || ud_send)) begin
                data_out <= core_rd_data;
            end
        end
    end

    // One word consumed per Multiword read strobe, or per cycle while ready
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_rd_take <= 1'b0;
        end else begin
            core_rd_take <= core_rd_valid & (ud_send | ((state_q ==
                            scio_pkg::SCIO_MW_XFER) & rd_rise));
        end
    end

    // ----------------------------------------
    // Write data capture
    // ----------------------------------------
    logic ud_cap;            // Ultra DMA strobe edge
    logic mw_cap;            // Multiword write trailing edge
    // Both strobe edges carry a word; idle strobe just waits
    assign ud_cap = (state_q == scio_pkg::SCIO_UD_OUT) & hstb_any;
    assign mw_cap = (state_q == scio_pkg::SCIO_MW_XFER) & wr_rise;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_wr_data  <= '0;
            core_wr_valid <= 1'b0;
        end else begin
            core_wr_valid <= ud_cap | mw_cap;
            if (ud_cap || mw_cap) begin
                core_wr_data <= din_s_q;
            end
        end
    end

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dev_is_master   <= 1'b0;
            udma_burst_stop <= 1'b0;
        end else begin
            // In True IDE, grounded pin selects master; pulled-up open pin is slave
            dev_is_master   <= mode_true_ide & ~cable_select_n_n;
            udma_burst_stop <= udma_active & stop & (state_q != scio_pkg::SCIO_IDLE) &
                               (state_q != scio_pkg::SCIO_REQ);
        end
    end
endmodule : scio_port

// ### test/scio_port_asserts.sv
`timescale 1ns/1ps
// ------
// Port timing checker
// ------
module scio_port_asserts (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic mode_io,
    input wire logic mode_true_ide,
    input wire logic udma_active,
    input wire logic udma_dir_in,
    input wire logic dev_selected,
    input wire logic drive_head_dev,
    input wire logic core_xfer_pending,
    input wire logic core_rd_take,
    input wire logic core_wr_valid,
    input wire logic dev_is_master,
    input wire logic host_io_read_strobe_n,
    input wire logic dma_ack_n,
    input wire logic host_dma_ready_n,
    input wire logic host_strobe,
    input wire logic cable_select_n,
    input wire logic data_oe,
    input wire logic input_ack_n,
    input wire logic dma_req_out,
    input wire logic dma_req_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Selected read held long enough to pass the sync
    sequence s_io_read;
        (mode_io && dev_selected && !udma_active && !host_io_read_strobe_n)[*5];
    endsequence
    // Write burst under way
    sequence s_ud_out;
        (udma_active && !udma_dir_in && !dma_ack_n)[*6];
    endsequence
    AST_ACK_ON_READ: assert property (s_io_read |-> !input_ack_n && data_oe)
        else $error("no acknowledge on read");
    AST_OE_IDLE: assert property ((host_io_read_strobe_n && !udma_active)[*4] |-> !data_oe)
        else $error("bus driven without strobe");
    AST_REQ_HOLD: assert property (dma_ack_n[*4] ##0 $past(dma_req_out) |-> dma_req_out)
        else $error("request dropped before ack");
    AST_REQ_RAISE: assert property
        ((core_xfer_pending && dma_ack_n && (!mode_true_ide || drive_head_dev))[*8] |-> dma_req_out)
        else $error("request not raised");
    AST_REQ_FLOAT: assert property ((mode_true_ide && !drive_head_dev)[*3] |-> !dma_req_oe)
        else $error("request driven unselected");
    AST_CAPTURE: assert property (s_ud_out ##0 $changed(host_strobe) |-> ##[1:4] core_wr_valid)
        else $error("strobe edge not captured");
    AST_PAUSE_IN: assert property
        ((udma_active && udma_dir_in && !dma_ack_n && host_dma_ready_n)[*4] |-> !core_rd_take)
        else $error("data sent while paused");
    AST_MASTER: assert property
        ((mode_true_ide && $stable(cable_select_n))[*5] |-> dev_is_master == !cable_select_n)
        else $error("master strap wrong");
endmodule : scio_port_asserts

bind scio_port scio_port_asserts u_chk (.*);

// ### test/scio_host_model.sv
`timescale 1ns/1ps
// ------
// Host controller model
// ------
module scio_host_model (
    input  wire logic   core_clk,
    input  wire logic   dma_req_out,
    output logic        card_enable_low_n,
    output logic        card_enable_high_n,
    output logic        host_io_read_strobe_n,
    output logic        host_io_write_strobe_n,
    output logic        dma_ack_n,
    output logic        host_dma_ready_n,
    output logic        host_strobe,
    output logic        udma_stop,
    output logic [15:0] data_in
);
    // Idle: all strobes and enables negated
    initial begin
        {card_enable_low_n, card_enable_high_n, host_io_read_strobe_n} = 3'h7;
        {host_io_write_strobe_n, dma_ack_n, host_dma_ready_n} = 3'h7;
        {host_strobe, udma_stop} = 2'h0;
        data_in = 16'hA5A5;
    end
    // Read cycle; held off while a request stands
    task automatic io_read(input int hold);
        @(posedge core_clk);
        while (dma_req_out === 1'b1) @(posedge core_clk);
        card_enable_low_n     <= 1'b0;
        host_io_read_strobe_n <= 1'b0;
        repeat (hold) @(posedge core_clk);
        card_enable_low_n     <= 1'b1;
        host_io_read_strobe_n <= 1'b1;
    endtask : io_read
    // Enables stay negated through DMA
    task automatic set_ack(input logic on);
        @(posedge core_clk);
        dma_ack_n <= !on;
    endtask : set_ack
    // Multiword write: word stands across the trailing strobe edge
    task automatic mw_write(input logic [15:0] w);
        @(posedge core_clk);
        data_in                <= w;
        host_io_write_strobe_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        host_io_write_strobe_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : mw_write
    // Ready and stop levels
    task automatic set_lines(input logic rdy, input logic stp);
        @(posedge core_clk);
        host_dma_ready_n <= !rdy;
        udma_stop        <= stp;
    endtask : set_lines
    // One word per strobe edge; a long gap is a pause
    task automatic ud_word(input logic [15:0] w, input int gap);
        @(posedge core_clk);
        data_in     <= w;
        host_strobe <= !host_strobe;
        repeat (gap) @(posedge core_clk);
        data_in     <= ~w;
    endtask : ud_word
endmodule : scio_host_model

// ### test/testbench.sv
`timescale 1ns/1ps
// ------
// Self-checking bench
// ------
module testbench;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        mode_io = 1'b0, mode_true_ide = 1'b0, udma_active = 1'b0;
    logic        udma_dir_in = 1'b0, dev_selected = 1'b1, drive_head_dev = 1'b0;
    logic        core_xfer_pending = 1'b0, core_rd_valid = 1'b0, cable_select_n = 1'b0;
    logic [15:0] core_rd_data = 16'h0000;
    logic [15:0] data_out, core_wr_data, data_in, w;
    logic        core_rd_take, core_wr_valid, dev_is_master, udma_burst_stop;
    logic        data_oe, input_ack_n, dma_req_out, dma_req_oe;
    logic        card_enable_low_n, card_enable_high_n, host_io_read_strobe_n;
    logic        host_io_write_strobe_n, dma_ack_n, host_dma_ready_n, host_strobe, udma_stop;
    int          seed = 24, n_mismatch = 0, num_checks = 0, cycles = 0;
    logic [15:0] exp_q[$];                  // Words sent, oldest first

    scio_port dut (.*);
    scio_host_model host (.*);

    always #25 core_clk = ~core_clk;

    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chk_word
    // Bounded wait, sampled where outputs are settled
    task automatic await(ref logic s, input int lim);
        repeat (lim) begin
            @(negedge core_clk);
            if (s === 1'b1) return;
        end
        chk_bit(1'b0, 1'b1, "wait ran out");
    endtask : await
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Watchdog: run needs well under this
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // Every capture must be the next word sent
    always @(negedge core_clk) begin
        if (core_wr_valid === 1'b1) begin
            chk_word(core_wr_data, exp_q.size() ? exp_q.pop_front() : 16'h0BAD);
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b         <= 1'b1;
        mode_true_ide <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk_bit(dev_is_master, 1'b1, "strap low");
        @(posedge core_clk);
        cable_select_n    <= 1'b1;
        core_xfer_pending <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk_bit(dev_is_master, 1'b0, "strap open");
        chk_bit(dma_req_oe, 1'b0, "unselected drive");
        @(posedge core_clk);
        drive_head_dev <= 1'b1;
        udma_active    <= 1'b1;
        repeat (12) @(negedge core_clk);
        chk_bit(dma_req_out, 1'b1, "request held");
        chk_bit(dma_req_oe, 1'b1, "selected drive");
        // Write burst, one long pause inside
        host.set_ack(1'b1);
        for (int i = 0; i < 6; i++) begin
            w = $random(seed);
            exp_q.push_back(w);
            host.ud_word(w, (i == 3) ? 14 : 3);
        end
        repeat (6) @(negedge core_clk);
        chk_bit(exp_q.size() == 0, 1'b1, "words lost");
        host.set_ack(1'b0);
        await(dma_req_out, 10);
        // Read burst: paused, then ready, then stopped
        @(posedge core_clk);
        udma_dir_in   <= 1'b1;
        core_rd_valid <= 1'b1;
        core_rd_data  <= $random(seed);
        host.set_ack(1'b1);
        repeat (10) @(negedge core_clk);
        chk_bit(core_rd_take, 1'b0, "sent while paused");
        host.set_lines(1'b1, 1'b0);
        await(core_rd_take, 10);
        host.set_lines(1'b0, 1'b1);
        await(udma_burst_stop, 10);
        host.set_lines(1'b0, 1'b0);
        host.set_ack(1'b0);
        @(posedge core_clk);
        core_xfer_pending <= 1'b0;
        repeat (6) @(posedge core_clk);
        {udma_active, mode_true_ide} <= 2'h0;
        // Multiword write: trailing edge of the write strobe captures
        @(posedge core_clk);
        core_xfer_pending <= 1'b1;
        host.set_ack(1'b1);
        repeat (4) @(posedge core_clk);
        w = $random(seed);
        exp_q.push_back(w);
        host.mw_write(w);
        host.set_ack(1'b0);
        @(posedge core_clk);
        core_xfer_pending <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk_bit(exp_q.size() == 0, 1'b1, "multiword word lost");
        // I/O then memory mode read
        for (int m = 1; m >= 0; m--) begin
            @(posedge core_clk);
            mode_io      <= m[0];
            w = $random(seed);
            core_rd_data <= w;
            repeat (4) @(posedge core_clk);
            fork
                host.io_read(9);
                begin
                    repeat (7) @(negedge core_clk);
                    chk_bit(input_ack_n, !m[0], "acknowledge");
                    chk_bit(data_oe, m[0], "read drive");
                    if (m == 1) chk_word(data_out, w);
                end
            join
            repeat (6) @(negedge core_clk);
            chk_bit(data_oe, 1'b0, "drive after strobe");
        end
        complete_run();
    end
endmodule : testbench
